// >>> logic/fbrla_read.sv
// Flash memory unit read path with read-ahead prefetch
`timescale 1ns/10ps
module fbrla_read
   import fbrla_pkg::*;
#(
   parameter int DW = DATA_W       // Read data width
)
(
   input  wire logic                   core_clk,   // Block clock
   input  wire logic                   rst,        // Synchronous reset, high
   input  wire fbrla_pkg::fbrla_req_s  req,        // Read request
   input  wire logic [DW-1:0]          array_q,    // Array word for addressed block
   input  wire logic [DW-1:0]          page_q,     // Page buffer word
   input  wire logic [DW-1:0]          status_q,   // Status register word
   output      fbrla_pkg::fbrla_blk_s  array_blk,  // Block fetched from array
   output      logic [WORD_W-1:0]      array_word, // Word index fetched
   output      logic                   busy,       // Busy, request must hold
   output      logic                   rd_valid,   // Read data valid pulse
   output      logic [DW-1:0]          rd_data     // Read data
);
   import fbrla_pkg::*;

   typedef enum logic [1:0] {FBRLA_IDLE, FBRLA_FETCH, FBRLA_MISS} fbrla_st_e;

   fbrla_st_e          st;
   logic [3:0]         cnt;
   logic [DW-1:0]      bbuf [BLK_WORDS];
   logic [DW-1:0]      pref [BLK_WORDS];
   fbrla_blk_s         bbuf_blk;
   fbrla_blk_s         pref_blk;
   logic               pref_done;
   logic               bbuf_ok;
   logic               miss_pend;
   fbrla_blk_s         miss_blk;
   logic [WORD_W-1:0]  fcnt;
   logic [3:0]         busy_cnt;
   logic               d1_valid;
   logic [DW-1:0]      d1_data;
   fbrla_blk_s         succ;

   fbrla_next_blk u_next (
      .cur (bbuf_blk),
      .nxt (succ)
   );

   wire rd_bb   = req.read && (req.src == FBRLA_SRC_BLOCK_BUF || req.src == FBRLA_SRC_ARRAY);
   wire in_buf  = bbuf_ok && (req.blk == bbuf_blk);
   wire hit_pf  = pref_done && (req.blk == pref_blk);
   wire miss    = rd_bb && !in_buf && !hit_pf && !busy;
   wire serve   = req.read && !busy && !miss;
   wire fetch_last = (fcnt == WORD_W'(BLK_WORDS - 1));

   wire [DW-1:0] src_data =
      (req.src == FBRLA_SRC_PAGE_BUF) ? page_q :
      (req.src == FBRLA_SRC_STATUS)   ? status_q :
      hit_pf                           ? pref[req.word] : bbuf[req.word];

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         st        <= FBRLA_IDLE;
         cnt       <= '0;
         fcnt      <= '0;
         pref_done <= 1'b0;
         bbuf_ok   <= 1'b0;
         miss_pend <= 1'b0;
         bbuf_blk  <= '0;
         pref_blk  <= '0;
         miss_blk  <= '0;
         busy      <= 1'b0;
         array_blk <= '0;
         array_word <= '0;
      end
      else
      begin
         case (st)
            FBRLA_IDLE:
            begin
               if (miss)
               begin
                  busy      <= 1'b1;
                  miss_blk  <= req.blk;
                  miss_pend <= 1'b1;
                  st        <= FBRLA_MISS;
                  cnt       <= ARRAY_RD_CNT;
                  fcnt      <= '0;
                  array_blk <= req.blk;
               end
               else if (serve && hit_pf)
               begin
                  bbuf_blk  <= pref_blk;
                  pref_done <= 1'b0;
               end
               else if (serve && req.read_ahead_request && in_buf && !pref_done)
               begin
                  pref_blk  <= succ;
                  array_blk <= succ;
                  st        <= FBRLA_FETCH;
                  fcnt      <= '0;
               end
            end
            FBRLA_FETCH:
            begin
               fcnt       <= fcnt + WORD_W'(1);
               array_word <= fcnt + WORD_W'(1);
               if (fetch_last)
               begin
                  pref_done <= 1'b1;
                  st        <= FBRLA_IDLE;
               end
               if (miss)
               begin
                  busy      <= 1'b1;
                  miss_blk  <= req.blk;
                  miss_pend <= 1'b1;
               end
               if (fetch_last && (miss || miss_pend))
               begin
                  st        <= FBRLA_MISS;
                  cnt       <= ARRAY_RD_CNT;
                  array_blk <= miss ? req.blk : miss_blk;
                  pref_done <= 1'b0;
               end
            end
            FBRLA_MISS:
            begin
               fcnt       <= fcnt + WORD_W'(1);
               array_word <= fcnt + WORD_W'(1);
               cnt        <= cnt - 4'h1;
               if (cnt == 4'h1)
               begin
                  bbuf_blk  <= miss_blk;
                  bbuf_ok   <= 1'b1;
                  miss_pend <= 1'b0;
                  busy      <= 1'b0;
                  st        <= FBRLA_IDLE;
               end
            end
            default: st <= FBRLA_IDLE;
         endcase
      end
   end

   // Array words land in prefetch or block buffer as fetched
   genvar gi;
   generate
      for (gi = 0; gi < BLK_WORDS; gi++)
      begin : g_buf
         always_ff @(posedge core_clk)
         begin
            if (rst)
            begin
               bbuf[gi] <= '0;
               pref[gi] <= '0;
            end
            else
            begin
               if (st == FBRLA_FETCH && fcnt == WORD_W'(gi))
                  pref[gi] <= array_q;
               if (st == FBRLA_MISS && fcnt == WORD_W'(gi))
                  bbuf[gi] <= array_q;
               else if (st == FBRLA_IDLE && serve && hit_pf)
                  bbuf[gi] <= pref[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         d1_valid <= 1'b0;
         d1_data  <= '0;
         rd_valid <= 1'b0;
         rd_data  <= '0;
         busy_cnt <= '0;
      end
      else
      begin
         d1_valid <= serve;
         d1_data  <= src_data;
         rd_valid <= req.pipe ? d1_valid : serve;
         rd_data  <= req.pipe ? d1_data : src_data;
         busy_cnt <= busy ? busy_cnt + 4'h1 : '0;
      end
   end

   chk_busy_bound: assert property (@(posedge core_clk) disable iff (rst)
      busy |-> busy_cnt < 4'(MISS_MAX_BUSY))
      else $error("busy lasted more than nine cycles");
   chk_hit_no_busy: assert property (@(posedge core_clk) disable iff (rst)
      (st == FBRLA_IDLE && req.read && hit_pf && !busy) |=> !busy)
      else $error("busy raised on prefetch hit");
   chk_miss_busy: assert property (@(posedge core_clk) disable iff (rst)
      (miss && st == FBRLA_IDLE) |=> busy)
      else $error("miss did not raise busy");
   chk_miss_ends: assert property (@(posedge core_clk) disable iff (rst)
      $rose(busy) |-> ##[1:9] !busy)
      else $error("miss never completed");
   chk_nopipe_lat: assert property (@(posedge core_clk) disable iff (rst)
      (serve && !req.pipe) |=> rd_valid)
      else $error("non-pipelined data late");
   chk_pipe_lat: assert property (@(posedge core_clk) disable iff (rst)
      (serve && req.pipe) ##1 req.pipe |=> rd_valid)
      else $error("pipelined data late");
   chk_status_src: assert property (@(posedge core_clk) disable iff (rst)
      (serve && !req.pipe && req.src == FBRLA_SRC_STATUS) |=> rd_data == $past(status_q))
      else $error("status source wrong");
   chk_prefetch_go: assert property (@(posedge core_clk) disable iff (rst)
      (st == FBRLA_IDLE && serve && req.read_ahead_request && in_buf && !pref_done && !hit_pf)
      |=> st == FBRLA_FETCH && pref_blk == $past(succ))
      else $error("prefetch did not start");

   cov_hit: cover property (@(posedge core_clk) serve && hit_pf);
   cov_miss: cover property (@(posedge core_clk) miss);
   cov_miss_in_fetch: cover property (@(posedge core_clk) st == FBRLA_FETCH && miss);
   cov_pipe: cover property (@(posedge core_clk) serve && req.pipe);
endmodule

// >>> logic/fbrla_pkg.sv
// Package: address layout, sources, timing and carrier structs for the read path
package fbrla_pkg;
   // Address layout: sector / page / block / word
   localparam int SECTOR_W     = 3;
   localparam int PAGE_W       = 3;
   localparam int BLOCK_W      = 3;
   localparam int WORD_W       = 2;
   localparam int ADDR_W       = SECTOR_W + PAGE_W + BLOCK_W + WORD_W;
   localparam int DATA_W       = 32;
   localparam int BLK_WORDS    = 4;
   // Page kinds within a sector
   localparam logic [PAGE_W-1:0] SPARE_PAGE = 3'h7;
   // Last data block of a page; the block after it holds auxiliary data
   localparam logic [BLOCK_W-1:0] LAST_DATA_BLK = 3'h6;
   localparam logic [BLOCK_W-1:0] AUX_BLK       = 3'h7;
   // Miss penalty
   localparam int MISS_MAX_BUSY = 9;
   localparam int ARRAY_RD_CYC  = 4;
   localparam logic [3:0] ARRAY_RD_CNT = 4'h4;

   typedef enum logic [1:0] {
      FBRLA_SRC_ARRAY,
      FBRLA_SRC_PAGE_BUF,
      FBRLA_SRC_BLOCK_BUF,
      FBRLA_SRC_STATUS
   } fbrla_src_e;

   typedef struct packed {
      logic [SECTOR_W-1:0] sector;
      logic [PAGE_W-1:0]   page;
      logic [BLOCK_W-1:0]  block;
   } fbrla_blk_s;

   typedef struct packed {
      logic                read;
      logic                read_ahead_request;
      logic                pipe;
      fbrla_src_e          src;
      fbrla_blk_s          blk;
      logic [WORD_W-1:0]   word;
   } fbrla_req_s;
endpackage

// >>> logic/fbrla_next_blk.sv
// Successor block computation for read-ahead
`timescale 1ns/10ps
module fbrla_next_blk
   import fbrla_pkg::*;
(
   input  wire fbrla_pkg::fbrla_blk_s cur,   // Block being read
   output      fbrla_pkg::fbrla_blk_s nxt    // Predicted successor
);
   wire is_spare = (cur.page == SPARE_PAGE);
   wire is_aux   = (cur.block == AUX_BLK);
   wire last_dat = (cur.block == LAST_DATA_BLK);
   // Sector advance wraps naturally to 0 past the last sector
   wire [SECTOR_W-1:0] sec_inc = cur.sector + {{(SECTOR_W-1){1'b0}}, 1'b1};
   wire [PAGE_W-1:0]   pg_inc  = cur.page + {{(PAGE_W-1){1'b0}}, 1'b1};
   wire [BLOCK_W-1:0]  blk_inc = cur.block + {{(BLOCK_W-1){1'b0}}, 1'b1};
   wire                pg_wrap = (cur.page == SPARE_PAGE - 3'h1);

   always_comb
   begin
      nxt = cur;
      if (is_aux)
      begin
         nxt.page = pg_inc;
         if (pg_inc == '0)
            nxt.sector = sec_inc;
      end
      else if (is_spare)
      begin
         nxt.sector = sec_inc;
         nxt.block  = '0;
      end
      else if (last_dat)
      begin
         nxt.block = '0;
         nxt.page  = pg_wrap ? '0 : pg_inc;
         if (pg_wrap)
            nxt.sector = sec_inc;
      end
      else
      begin
         nxt.block = blk_inc;
      end
   end
endmodule

// >>> test/fbrla_user_model.sv
// Fabric-side read master that holds each request through busy
`timescale 1ns/10ps
module fbrla_user_model
   import fbrla_pkg::*;
(
   input  wire logic                  core_clk,   // Block clock
   input  wire logic                  rst,        // Synchronous reset, high
   input  wire logic                  go,         // Start one read
   input  wire fbrla_pkg::fbrla_req_s cmd,        // Read to issue
   input  wire logic                  busy,       // Device busy
   output      fbrla_pkg::fbrla_req_s req,        // Request to device
   output      logic [7:0]            n_done,     // Served read count
   output      logic [15:0]           take_edge,  // Edge index of last serve
   output      logic [3:0]            busy_n      // Busy cycles of last read
);
   import fbrla_pkg::*;
   fbrla_req_s  rel;
   logic [15:0] edge_cnt;
   logic        took;
   initial
   begin
      req = '0;
      n_done = 8'h00;
      take_edge = 16'h0000;
      busy_n = 4'h0;
      edge_cnt = 16'h0000;
   end
   always @(posedge core_clk)
   begin
      took = req.read && !busy && !rst;
      edge_cnt <= edge_cnt + 16'h0001;
      if (req.read && busy && busy_n != 4'hF)
         busy_n <= busy_n + 4'h1;
      if (rst)
         req <= '0;
      else if (go)
      begin
         req <= cmd;
         busy_n <= 4'h0;
      end
      #1;
      if (took && !busy)
      begin
         rel = fbrla_req_s'(~req);
         rel.read = 1'b0;
         rel.pipe = req.pipe;
         req <= rel;
         take_edge <= edge_cnt;
         n_done <= n_done + 8'h01;
      end
   end
endmodule

// >>> test/tb.sv
// Testbench: sources, read latency, misses and read-ahead successors
`timescale 1ns/10ps
module tb;
   import fbrla_pkg::*;
   logic              core_clk;
   logic              rst;
   logic              go;
   fbrla_req_s        cmd;
   fbrla_req_s        req;
   fbrla_blk_s        array_blk;
   logic [WORD_W-1:0] array_word;
   logic              busy;
   logic              rd_valid;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] stat;
   logic [7:0]        n_done;
   logic [15:0]       take_edge;
   logic [3:0]        busy_n;
   logic [15:0]       cyc;
   logic [47:0]       exp_q[$];
   logic [47:0]       got;
   integer            seed;
   int                errors;
   int                checked;
   int                k;

   function automatic logic [31:0] arr_w(input fbrla_blk_s b, input logic [1:0] w);
      return {8'hA5, 13'h0000, b, w};
   endfunction
   function automatic logic [31:0] pg_w(input fbrla_blk_s b, input logic [1:0] w);
      return {8'h3C, 13'h0000, b, w};
   endfunction

   fbrla_read #(.DW(DATA_W)) uut (.core_clk(core_clk), .rst(rst), .req(req),
      .array_q(arr_w(array_blk, array_word)), .page_q(pg_w(req.blk, req.word)),
      .status_q(stat), .array_blk(array_blk), .array_word(array_word), .busy(busy),
      .rd_valid(rd_valid), .rd_data(rd_data));
   fbrla_user_model usr (.core_clk(core_clk), .rst(rst), .go(go), .cmd(cmd), .busy(busy),
      .req(req), .n_done(n_done), .take_edge(take_edge), .busy_n(busy_n));

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
      cyc <= cyc + 16'h0001;

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want)
      begin
         errors++;
         $display("mismatch at %0t: seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic give_verdict;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // One read; bx: 1 miss, 2 hit, 3 miss behind prefetch
   task automatic rd(input fbrla_blk_s b, input logic [1:0] w, input fbrla_src_e s,
                     input logic ra, input logic p, input int bx);
      fbrla_req_s  c;
      logic [7:0]  n0;
      logic [31:0] e;
      int          n;
      c = {1'b1, ra, p, s, b, w};
      n0 = n_done;
      e = (s == FBRLA_SRC_PAGE_BUF) ? pg_w(b, w) : (s == FBRLA_SRC_STATUS) ? stat : arr_w(b, w);
      exp_q.push_back({e, 15'h0000, p});
      cmd <= c;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      n = 0;
      while (n_done === n0 && n < 40)
      begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 40)
      begin
         errors++;
         give_verdict();
      end
      chk({31'h0, busy_n <= 4'h9}, 32'h1);
      if (bx == 1)
         chk({31'h0, busy_n != 4'h0}, 32'h1);
      if (bx == 2)
         chk({28'h0, busy_n}, 32'h0);
      if (bx == 3)
         chk({31'h0, busy_n > ARRAY_RD_CYC}, 32'h1);
   endtask

   // Read with read-ahead, let the prefetch land, then read the successor
   task automatic succ(input fbrla_blk_s cur, input fbrla_blk_s nxt);
      int r;
      r = $random(seed);
      rd(cur, r[1:0], FBRLA_SRC_BLOCK_BUF, 1'b1, r[2], 0);
      repeat (10) @(posedge core_clk);
      rd(nxt, r[4:3], FBRLA_SRC_BLOCK_BUF, 1'b0, r[2], 2);
   endtask

   // Result watcher, oldest note first
   always @(negedge core_clk)
      if (rd_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk(32'h1, 32'h0);
         else
         begin
            got = exp_q.pop_front();
            chk(rd_data, got[47:16]);
            chk({16'h0000, cyc}, {16'h0000, take_edge + got[15:0]});
         end
      end

   initial
   begin
      repeat (20000) @(posedge core_clk);
      errors++;
      give_verdict();
   end

   initial
   begin
      seed = 32'hBE80;
      rst = 1'b1;
      go = 1'b0;
      cmd = '0;
      cyc = 16'h0000;
      errors = 0;
      checked = 0;
      stat = $random(seed);
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      chk({30'h0, busy, rd_valid}, 32'h0);
      for (int p = 0; p < 2; p++)
         for (int s = 0; s < 4; s++)
            rd({3'h4, 3'h1, p[0], s[1:0]}, 2'(s + p), fbrla_src_e'(s), 1'b0, p[0],
               (s % 2 == 0) ? 1 : 0);
      succ({3'h1, 3'h2, 3'h3}, {3'h1, 3'h2, 3'h4});
      succ({3'h1, 3'h2, 3'h6}, {3'h1, 3'h3, 3'h0});
      succ({3'h1, 3'h7, 3'h2}, {3'h2, 3'h7, 3'h0});
      succ({3'h7, 3'h7, 3'h1}, {3'h0, 3'h7, 3'h0});
      succ({3'h2, 3'h3, 3'h7}, {3'h2, 3'h4, 3'h7});
      rd({3'h3, 3'h1, 3'h1}, 2'h1, FBRLA_SRC_BLOCK_BUF, 1'b1, 1'b0, 0);
      rd({3'h5, 3'h5, 3'h5}, 2'h2, FBRLA_SRC_ARRAY, 1'b0, 1'b0, 3);
      k = 0;
      while (exp_q.size() != 0 && k < 20)
      begin
         @(posedge core_clk);
         k++;
      end
      chk(exp_q.size(), 32'h0);
      give_verdict();
   end
endmodule
